// ==== hdl/sac_consts.svh ====
/*
 Constants for the converter control block: register addresses, field positions,
 reset values and clock-rate counts.
 Assumes a 125 MHz core clock and an 8-bit special-register space.
*/
`ifndef SAC_CONSTS_SVH
`define SAC_CONSTS_SVH

`define SAC_ADDR_CHSEL      8'h0A
`define SAC_ADDR_RES_LO     8'h0B
`define SAC_ADDR_RES_HI     8'h0C
`define SAC_ADDR_CLKCTL     8'h0D
`define SAC_GO_BIT          7
`define SAC_CHSEL_RST       8'h1F
`define SAC_RES_LO_RST      8'h00
`define SAC_RES_HI_RST      8'h00
`define SAC_CLKCTL_RST      8'h00
`define SAC_NUM_CHAN        24
`define SAC_CONV_CLOCKS     12
`define SAC_SYS_HZ          125000000
`define SAC_CONV_HZ_FAST    256000
// Fastest divider count; slower settings double it per step
`define SAC_DIV_FAST        ((`SAC_SYS_HZ) / (`SAC_CONV_HZ_FAST))

`endif

// ==== hdl/sac_pkg.sv ====
/*
 Types shared by the converter control files.
 Assumes the constants header is included by users where needed.
*/
package sac_pkg;
   typedef enum logic [1:0] {
      SAC_IDLE,
      SAC_CONV,
      SAC_DONE
   } sac_state_t;
endpackage

// ==== hdl/sac_step_if.sv ====
/*
 Interface between the control top and its conversion clock divider.
 Assumes both ends share sys_clk.
*/
`timescale 1ns/1ns
`default_nettype none
interface sac_step_if;
   logic [1:0] rate_sel;
   logic       run;
   logic       tick;
   modport ctrl (output rate_sel, output run, input tick);
   modport div  (input rate_sel, input run, output tick);
endinterface
`default_nettype wire

// ==== hdl/sac_clk_div.sv ====
/*
 Conversion clock divider: one-cycle tick per conversion clock period.
 Assumes run drops between conversions so each one restarts phase.
*/
`timescale 1ns/1ns
`default_nettype none
`include "sac_consts.svh"
module sac_clk_div #(
   parameter int DIV_FAST = `SAC_DIV_FAST
) (
   input  wire logic sys_clk,
   input  wire logic nrst,
   sac_step_if.div   stp
);
   typedef struct packed {
      logic [15:0] cnt;
      logic        tick;
   } sac_div_st_t;

   sac_div_st_t st_r;
   sac_div_st_t st_nxt;
   logic [15:0] limit;

   assign limit = 16'((DIV_FAST << stp.rate_sel) - 1);

   always_comb begin
      st_nxt = st_r;
      st_nxt.tick = 1'b0;
      if (!stp.run) begin
         st_nxt.cnt = 16'h0000;
      end else if (st_r.cnt >= limit) begin
         st_nxt.cnt = 16'h0000;
         st_nxt.tick = 1'b1;
      end else begin
         st_nxt.cnt = st_r.cnt + 16'h0001;
      end
   end

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign stp.tick = st_r.tick;
endmodule
`default_nettype wire

// ==== hdl/sac_ctrl.sv ====
/*
 Converter control: channel select, go flag, clock select, result registers,
 successive-approximation sequencer and analog pin enables.
 Assumes a core bus with byte address, write strobe and combinational read;
 the analog comparator answers cmp_high within one cycle of a trial code.
*/
`timescale 1ns/1ns
`default_nettype none
`include "sac_consts.svh"
module sac_ctrl #(
   parameter int DIV_FAST = `SAC_DIV_FAST
) (
   input  wire logic       sys_clk,
   input  wire logic       nrst,
   input  wire logic [7:0] reg_addr,
   input  wire logic       reg_wr,
   input  wire logic [7:0] reg_wdata,
   output logic      [7:0] reg_rdata,
   output logic            reg_hit,
   input  wire logic       bank_sel,
   output logic      [7:0] trial_code_hi,
   output logic      [1:0] trial_code_lo,
   input  wire logic       cmp_high,
   output logic      [7:0] port5_ana_en,
   output logic      [7:0] port8_ana_en,
   output logic      [7:0] port6_ana_en,
   output logic            busy
);
   typedef struct packed {
      sac_pkg::sac_state_t state;
      logic                go;
      logic [4:0]          chan;
      logic [1:0]          rate;
      logic [9:0]          result;
      logic [9:0]          trial;
      logic [3:0]          step;
      logic [2:0]          bank_s;
      logic [2:0]          cmp_s;
      logic                bank_f;
      logic                cmp_f;
   } sac_st_t;

   localparam logic [7:0] CHSEL_RST = `SAC_CHSEL_RST;

   sac_st_t     st_r;
   sac_st_t     st_nxt;
   sac_step_if  stp ();
   logic        sel_chsel;
   logic        sel_lo;
   logic        sel_hi;
   logic        sel_clk;
   logic        bank_on;
   logic        cmp_bit;
   logic [23:0] ana_en;

   sac_clk_div #(
      .DIV_FAST (DIV_FAST)
   ) u_div (
      .sys_clk (sys_clk),
      .nrst    (nrst),
      .stp     (stp)
   );

   assign stp.rate_sel = st_r.rate;
   assign stp.run      = (st_r.state == sac_pkg::SAC_CONV);

   // Bank bit and comparator are asynchronous; a change counts once stages two and three
   // agree, otherwise the last agreed level holds so a glitch cannot flip either
   assign bank_on = (st_r.bank_s[2] == st_r.bank_s[1]) ? st_r.bank_s[1] : st_r.bank_f;
   assign cmp_bit = (st_r.cmp_s[2] == st_r.cmp_s[1]) ? st_r.cmp_s[1] : st_r.cmp_f;

   always_comb begin
      sel_chsel = 1'b0;
      sel_lo    = 1'b0;
      sel_hi    = 1'b0;
      sel_clk   = 1'b0;
      if (!bank_on) begin
         sel_chsel = 1'b0;
      end else if (reg_addr == `SAC_ADDR_CHSEL) begin
         sel_chsel = 1'b1;
      end else if (reg_addr == `SAC_ADDR_RES_LO) begin
         sel_lo = 1'b1;
      end else if (reg_addr == `SAC_ADDR_RES_HI) begin
         sel_hi = 1'b1;
      end else if (reg_addr == `SAC_ADDR_CLKCTL) begin
         sel_clk = 1'b1;
      end
   end

   assign reg_hit = sel_chsel | sel_lo | sel_hi | sel_clk;

   always_comb begin
      reg_rdata = 8'h00;
      if (sel_chsel) begin
         reg_rdata = {st_r.go, 2'b00, st_r.chan};
      end else if (sel_lo) begin
         reg_rdata = {st_r.result[1:0], 6'b00_0000};
      end else if (sel_hi) begin
         reg_rdata = st_r.result[9:2];
      end else if (sel_clk) begin
         reg_rdata = {6'b00_0000, st_r.rate};
      end
   end

   always_comb begin
      st_nxt = st_r;
      st_nxt.bank_s = {st_r.bank_s[1:0], bank_sel};
      st_nxt.cmp_s  = {st_r.cmp_s[1:0], cmp_high};
      st_nxt.bank_f = bank_on;
      st_nxt.cmp_f  = cmp_bit;
      if (sel_clk && reg_wr) begin
         st_nxt.rate = reg_wdata[1:0];
      end
      if (sel_chsel && reg_wr) begin
         st_nxt.chan = reg_wdata[4:0];
         // start on 0 to 1; a 1 to 0 write cannot abort
         if (reg_wdata[`SAC_GO_BIT] && !st_r.go) begin
            st_nxt.go = 1'b1;
         end
      end
      case (st_r.state)
         sac_pkg::SAC_IDLE: begin
            if (st_nxt.go) begin
               st_nxt.state = sac_pkg::SAC_CONV;
               st_nxt.step  = 4'h0;
               st_nxt.trial = 10'h200;
            end
         end
         sac_pkg::SAC_CONV: begin
            // twelve conversion clocks: ten bit trials plus two
            if (stp.tick) begin
               st_nxt.step = st_r.step + 4'h1;
               // binary search one bit per clock
               if (st_r.step < 4'd10) begin
                  if (cmp_bit) begin
                     st_nxt.trial[4'd9 - st_r.step] = 1'b0;
                  end
                  if (st_r.step < 4'd9) begin
                     st_nxt.trial[4'd8 - st_r.step] = 1'b1;
                  end
               end
               if (st_r.step == 4'(`SAC_CONV_CLOCKS - 1)) begin
                  st_nxt.result = st_r.trial;
                  st_nxt.state  = sac_pkg::SAC_DONE;
               end
            end
         end
         sac_pkg::SAC_DONE: begin
            // go cleared a cycle after transfer
            st_nxt.go    = 1'b0;
            st_nxt.state = sac_pkg::SAC_IDLE;
         end
         default: begin
            st_nxt.state = sac_pkg::SAC_IDLE;
         end
      endcase
   end

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         st_r.state  <= sac_pkg::SAC_IDLE;
         st_r.go     <= CHSEL_RST[`SAC_GO_BIT];
         st_r.chan   <= CHSEL_RST[4:0];
         st_r.rate   <= 2'(`SAC_CLKCTL_RST);
         st_r.result <= 10'h000;
         st_r.trial  <= 10'h000;
         st_r.step   <= 4'h0;
         st_r.bank_s <= 3'b000;
         st_r.cmp_s  <= 3'b000;
         st_r.bank_f <= 1'b0;
         st_r.cmp_f  <= 1'b0;
      end else begin
         st_r <= st_nxt;
      end
   end

   // pin mapping, one pin, codes above 23 select none
   genvar gi;
   generate
      for (gi = 0; gi < `SAC_NUM_CHAN; gi = gi + 1) begin : g_en
         assign ana_en[gi] = (st_r.chan == 5'(gi));
      end
   endgenerate

   assign port5_ana_en  = ana_en[7:0];
   assign port8_ana_en  = ana_en[15:8];
   assign port6_ana_en  = ana_en[23:16];
   assign trial_code_hi = st_r.trial[9:2];
   assign trial_code_lo = st_r.trial[1:0];
   assign busy          = st_r.go;

   chk_go_clears: assert property (@(posedge sys_clk) disable iff (!nrst)
      (st_r.state == sac_pkg::SAC_DONE) |=> !st_r.go)
      else $error("go flag not cleared after done");
   chk_result_first: assert property (@(posedge sys_clk) disable iff (!nrst)
      $fell(st_r.go) |-> $past(st_r.state) == sac_pkg::SAC_DONE)
      else $error("go cleared without result transfer");
   chk_one_pin: assert property (@(posedge sys_clk) disable iff (!nrst)
      $countones(ana_en) <= 1)
      else $error("more than one analog pin enabled");
   chk_no_pin_hi: assert property (@(posedge sys_clk) disable iff (!nrst)
      (st_r.chan >= 5'd24) |-> (ana_en == 24'h00_0000))
      else $error("high code enabled a pin");
   chk_pin_map: assert property (@(posedge sys_clk) disable iff (!nrst)
      (st_r.chan == 5'd16) |-> port6_ana_en[0])
      else $error("code 16 not routed to port 6 bit 0");
   chk_start_edge: assert property (@(posedge sys_clk) disable iff (!nrst)
      (st_r.state == sac_pkg::SAC_IDLE && st_r.go) |=> st_r.state == sac_pkg::SAC_CONV)
      else $error("start not taken");
   chk_bank_gate: assert property (@(posedge sys_clk) disable iff (!nrst)
      !bank_on |-> !reg_hit && reg_rdata == 8'h00)
      else $error("register visible with bank clear");
   chk_low_zero: assert property (@(posedge sys_clk) disable iff (!nrst)
      sel_lo |-> reg_rdata[5:0] == 6'b00_0000)
      else $error("low result low bits not zero");
   chk_high_map: assert property (@(posedge sys_clk) disable iff (!nrst)
      sel_hi |-> reg_rdata == st_r.result[9:2])
      else $error("high result layout wrong");
   chk_twelve_ticks: assert property (@(posedge sys_clk) disable iff (!nrst)
      (stp.tick && st_r.step == 4'd11) |=> st_r.state == sac_pkg::SAC_DONE)
      else $error("conversion did not end at twelfth clock");
   chk_rate_slow: assert property (@(posedge sys_clk) disable iff (!nrst)
      (stp.tick && st_r.rate == 2'b11 && st_r.state == sac_pkg::SAC_CONV && $stable(st_r.rate))
      |=> !stp.tick [*8])
      else $error("slowest rate ticks too often");
   chk_bit_search: assert property (@(posedge sys_clk) disable iff (!nrst)
      (st_r.state == sac_pkg::SAC_IDLE && st_r.go) |=> st_r.trial == 10'h200)
      else $error("search does not start at midscale");
endmodule
`default_nettype wire

// ==== tb/sac_ana_model.sv ====
/*
 Analog pins and comparator seen from the converter.
 Assumes the bench sets one level per channel pin.
*/
`timescale 1ns/1ns
`default_nettype none
module sac_ana_model (
   input  wire logic        sys_clk,
   input  wire logic [23:0] ana_en,
   input  wire logic [9:0]  pin_lvl [24],
   input  wire logic [7:0]  trial_hi,
   input  wire logic [1:0]  trial_lo,
   output logic             cmp_high
);
   logic       flip_r = 1'b0;
   logic       hit;
   logic [9:0] lvl;
   // Floating input churns so nothing settles by luck
   always_ff @(posedge sys_clk) flip_r <= ~flip_r;
   always_comb begin
      hit = 1'b0;
      lvl = 10'h000;
      for (int i = 0; i < 24; i++) begin
         if (ana_en[i]) begin
            hit = 1'b1;
            lvl = pin_lvl[i];
         end
      end
   end
   assign cmp_high = hit ? (lvl < {trial_hi, trial_lo}) : flip_r;
endmodule
`default_nettype wire

// ==== tb/sar_adc_control_tb.sv ====
/*
 Self-checking bench for the converter control.
 Assumes a short divider so conversions stay brief.
*/
`timescale 1ns/1ns
`default_nettype none
`include "sac_consts.svh"
module sar_adc_control_tb;
   localparam int DIV = 4;
   logic       sys_clk = 1'b0;
   logic       nrst = 1'b0;
   logic [7:0] reg_addr = 8'h00;
   logic       reg_wr = 1'b0;
   logic [7:0] reg_wdata = 8'h00;
   logic       bank_sel = 1'b1;
   logic [7:0] reg_rdata, trial_hi, p5, p8, p6, rd;
   logic [1:0] trial_lo;
   logic       reg_hit, cmp_high, busy;
   logic [9:0] pin_lvl [24];
   int         errors = 0;
   int         checks_done = 0;
   integer     seed = 32'h54fa;

   sac_ctrl #(.DIV_FAST(DIV)) i_dut (.sys_clk(sys_clk), .nrst(nrst),
      .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
      .reg_rdata(reg_rdata), .reg_hit(reg_hit), .bank_sel(bank_sel),
      .trial_code_hi(trial_hi), .trial_code_lo(trial_lo), .cmp_high(cmp_high),
      .port5_ana_en(p5), .port8_ana_en(p8), .port6_ana_en(p6), .busy(busy));
   sac_ana_model i_ana (.sys_clk(sys_clk), .ana_en({p6, p8, p5}), .pin_lvl(pin_lvl),
      .trial_hi(trial_hi), .trial_lo(trial_lo), .cmp_high(cmp_high));

   always #4 sys_clk = ~sys_clk;

   task automatic give_verdict;
      if (errors == 0 && checks_done > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   task automatic check(input logic [23:0] seen, input logic [23:0] exp);
      checks_done++;
      if (seen !== exp) begin
         errors++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
   endtask

   task automatic rd_reg(input logic [7:0] a);
      @(posedge sys_clk);
      reg_addr <= a;
      @(negedge sys_clk);
      rd = reg_rdata;
   endtask

   function automatic logic [23:0] exp_en(input logic [4:0] ch);
      return (ch < 5'd24) ? (24'h000001 << ch) : 24'h000000;
   endfunction

   task automatic convert(input logic [4:0] ch, input logic [1:0] rate);
      int cnt;
      int len;
      len = (DIV << rate) * 12;
      wr(`SAC_ADDR_CLKCTL, {6'h00, rate});
      wr(`SAC_ADDR_CHSEL, {3'b100, ch});
      cnt = 0;
      @(negedge sys_clk);
      check(busy, 1'b1);
      check({p6, p8, p5}, exp_en(ch));
      while (busy !== 1'b0 && cnt < 20000) begin
         @(negedge sys_clk);
         cnt++;
      end
      if (cnt >= 20000) begin
         errors++;
         give_verdict();
      end
      check(cnt >= len - 3 && cnt <= len + 4, 1'b1);
      if (ch < 5'd24) begin
         rd_reg(`SAC_ADDR_RES_LO);
         check(rd, {pin_lvl[ch][1:0], 6'h00});
         rd_reg(`SAC_ADDR_RES_HI);
         check(rd, pin_lvl[ch][9:2]);
      end
      rd_reg(`SAC_ADDR_CHSEL);
      check(rd, {3'b000, ch});
      rd_reg(`SAC_ADDR_CLKCTL);
      check(rd, {6'h00, rate});
   endtask

   initial begin
      for (int i = 0; i < 24; i++) begin
         pin_lvl[i] = 10'($random(seed));
      end
      // Code extremes on the first and last pin
      pin_lvl[0]  = 10'h000;
      pin_lvl[23] = 10'h3FF;
      repeat (8) @(posedge sys_clk);
      nrst <= 1'b1;
      repeat (4) @(posedge sys_clk);
      rd_reg(`SAC_ADDR_CHSEL);
      check(rd, `SAC_CHSEL_RST);
      check({p6, p8, p5}, 24'h000000);
      for (int a = 8'h0B; a <= 8'h0D; a++) begin
         rd_reg(8'(a));
         check(rd, 8'h00);
      end
      bank_sel <= 1'b0;
      repeat (4) @(posedge sys_clk);
      wr(`SAC_ADDR_CLKCTL, 8'h03);
      rd_reg(`SAC_ADDR_CLKCTL);
      check({reg_hit, rd}, 9'h000);
      bank_sel <= 1'b1;
      repeat (4) @(posedge sys_clk);
      rd_reg(`SAC_ADDR_CLKCTL);
      check({reg_hit, rd}, 9'h100);
      convert(5'd0, 2'd0);
      convert(5'd23, 2'd3);
      for (int n = 0; n < 6; n++) begin
         convert(5'($unsigned($random(seed)) % 24), 2'(n));
      end
      convert(5'd24, 2'd1);
      convert(5'd31, 2'd0);
      give_verdict();
   end
endmodule
`default_nettype wire
